// [pcs_codec_port.sv]
// Top of the PCM codec serial port: APB registers, format, link crossing.
// Assumes a TDM bus controller supplying bit clock, frame sync and select.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none

module pcs_codec_port (
    input wire logic clk_in,                          // System clock
    input wire logic rst_n_in,                        // Sync reset, low
    input wire logic psel_in,                         // APB select
    input wire logic penable_in,                      // APB enable
    input wire logic pwrite_in,                       // APB direction
    input wire logic [pcs_pkg::ADDR_W-1:0] paddr_in,  // APB address
    input wire logic [pcs_pkg::DATA_W-1:0] pwdata_in, // APB write data
    output logic [pcs_pkg::DATA_W-1:0] prdata_out,    // APB read data
    output logic pready_out,                          // APB ready
    output logic pslverr_out,                         // APB error
    input wire logic bclk_in,                         // PCM bit clock
    input wire logic frame_sync_in,                   // Frame sync
    input wire logic chan_sel_n_in,                   // Channel select, low
    input wire logic pcm_rx_in,                       // Serial receive data
    output logic pcm_tx_out,                          // Serial transmit data
    output logic pcm_tx_oe_out,                       // Transmit enable
    output logic analog_rx_out,                       // Analog out grounded
    output logic tx_gain_low_out,                     // Transmit -3 dB
    output logic rx_gain_boost_out,                   // Receive +3 dB
    output logic law_alaw_out,                        // A-law selected
    output logic tx_conv_en_out,                      // Transmit half on
    output logic rx_conv_en_out                       // Receive half on
);
    import pcs_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [CODE_W-1:0] txcode_reg;
    logic [CODE_W-1:0] rxcode_reg;
    logic [CODE_W-1:0] tx_shadow_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic rx_new_reg;
    logic rx_tgl_s1_reg;
    logic rx_tgl_s2_reg;
    logic rx_tgl_s3_reg;
    logic act_s1_reg;
    logic act_s2_reg;
    logic mute_reg;
    logic txg_low_reg;
    logic rxg_boost_reg;
    logic alaw_reg;
    logic tx_en_reg;
    logic rx_en_reg;
    logic [CODE_W-1:0] link_rx_word;
    logic link_rx_tgl;
    logic link_active;
    logic wr_acc;
    logic rd_setup;
    logic addr_ok;
    logic rx_evt;
    logic rx_take;
    logic clr_new;

    // Line format is a fixed XOR pattern per law, its own inverse
    function automatic logic [CODE_W-1:0] pcs_fmt(
        input logic [CODE_W-1:0] code,
        input logic mu
    );
        pcs_fmt = code ^ (mu ? MU_MASK : A_MASK);
    endfunction

    function automatic logic pcs_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        pcs_hit = (addr == off);
    endfunction

    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
    assign addr_ok = pcs_hit(paddr_in, OFF_CTRL)
        | pcs_hit(paddr_in, OFF_TXCODE)
        | pcs_hit(paddr_in, OFF_RXCODE)
        | pcs_hit(paddr_in, OFF_STATUS);
    assign pready_out = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    assign prdata_out = prdata_reg;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else if (wr_acc && pcs_hit(paddr_in, OFF_CTRL))
        begin
            ctrl_reg <= pwdata_in[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            txcode_reg <= CODE_ZERO;
        end
        else if (wr_acc && pcs_hit(paddr_in, OFF_TXCODE))
        begin
            txcode_reg <= pwdata_in[CODE_W-1:0];
        end
    end

    // Frame completion arrives as a toggle from the bit clock domain
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_tgl_s1_reg <= 1'b0;
            rx_tgl_s2_reg <= 1'b0;
            rx_tgl_s3_reg <= 1'b0;
            act_s1_reg <= 1'b0;
            act_s2_reg <= 1'b0;
        end
        else
        begin
            rx_tgl_s1_reg <= link_rx_tgl;
            rx_tgl_s2_reg <= rx_tgl_s1_reg;
            rx_tgl_s3_reg <= rx_tgl_s2_reg;
            act_s1_reg <= link_active;
            act_s2_reg <= act_s1_reg;
        end
    end

    assign rx_evt = rx_tgl_s2_reg ^ rx_tgl_s3_reg;
    assign rx_take = rx_evt & ~ctrl_reg[CTRL_RXSLP];
    assign clr_new = wr_acc & pcs_hit(paddr_in, OFF_STATUS)
        & pwdata_in[STAT_RXNEW];

    // Received word is stable for a whole frame after its toggle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rxcode_reg <= CODE_ZERO;
        end
        else if (rx_take)
        begin
            rxcode_reg <= pcs_fmt(link_rx_word, ctrl_reg[CTRL_LAW]);
        end
    end

    // Shadow changes just after a frame, far from the next frame start
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            tx_shadow_reg <= LINE_IDLE;
        end
        else if (rx_evt)
        begin
            tx_shadow_reg <= pcs_fmt(txcode_reg, ctrl_reg[CTRL_LAW]);
        end
    end

    // New-sample flag: a set in the clearing cycle wins
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_new_reg <= 1'b0;
        end
        else
        begin
            rx_new_reg <= rx_take | (rx_new_reg & ~clr_new);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            mute_reg <= CTRL_RESET[CTRL_RXSLP];
            txg_low_reg <= ~CTRL_RESET[CTRL_TXG];
            rxg_boost_reg <= CTRL_RESET[CTRL_RXG];
            alaw_reg <= ~CTRL_RESET[CTRL_LAW];
            tx_en_reg <= ~CTRL_RESET[CTRL_TXSLP];
            rx_en_reg <= ~CTRL_RESET[CTRL_RXSLP];
        end
        else
        begin
            mute_reg <= ctrl_reg[CTRL_RXSLP];
            txg_low_reg <= ~ctrl_reg[CTRL_TXG];
            rxg_boost_reg <= ctrl_reg[CTRL_RXG];
            alaw_reg <= ~ctrl_reg[CTRL_LAW];
            tx_en_reg <= ~ctrl_reg[CTRL_TXSLP];
            rx_en_reg <= ~ctrl_reg[CTRL_RXSLP];
        end
    end

    assign analog_rx_out = mute_reg;
    assign tx_gain_low_out = txg_low_reg;
    assign rx_gain_boost_out = rxg_boost_reg;
    assign law_alaw_out = alaw_reg;
    assign tx_conv_en_out = tx_en_reg;
    assign rx_conv_en_out = rx_en_reg;

    // Read data is captured in the setup cycle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            prdata_reg <= WORD_ZERO;
        end
        else if (rd_setup)
        begin
            if (pcs_hit(paddr_in, OFF_CTRL))
            begin
                prdata_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
            end
            else if (pcs_hit(paddr_in, OFF_TXCODE))
            begin
                prdata_reg <= {{(DATA_W-CODE_W){1'b0}}, txcode_reg};
            end
            else if (pcs_hit(paddr_in, OFF_RXCODE))
            begin
                prdata_reg <= {{(DATA_W-CODE_W){1'b0}}, rxcode_reg};
            end
            else if (pcs_hit(paddr_in, OFF_STATUS))
            begin
                prdata_reg <= WORD_ZERO;
                prdata_reg[STAT_ACTIVE] <= act_s2_reg;
                prdata_reg[STAT_RXNEW] <= rx_new_reg;
            end
            else
            begin
                prdata_reg <= WORD_ZERO;
            end
        end
    end

    pcs_link u_link (
        .bclk_in(bclk_in),
        .rst_n_in(rst_n_in),
        .frame_sync_in(frame_sync_in),
        .chan_sel_n_in(chan_sel_n_in),
        .pcm_rx_in(pcm_rx_in),
        .tx_sleep_in(ctrl_reg[CTRL_TXSLP]),
        .tx_word_in(tx_shadow_reg),
        .pcm_tx_out(pcm_tx_out),
        .pcm_tx_oe_out(pcm_tx_oe_out),
        .rx_word_out(link_rx_word),
        .rx_tgl_out(link_rx_tgl),
        .active_out(link_active)
    );

    default clocking cb_sys @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_rx_frame;
        rx_evt && !ctrl_reg[CTRL_RXSLP];
    endsequence

    sequence s_rx_asleep;
        rx_evt && ctrl_reg[CTRL_RXSLP];
    endsequence

    a_rx_decode: assert property (s_rx_frame |=> rxcode_reg ==
        ($past(link_rx_word) ^ ($past(ctrl_reg[CTRL_LAW]) ? MU_MASK
        : A_MASK)))
        else $error("Received code not formatted per law");
    a_rx_sleep_hold: assert property (s_rx_asleep |=>
        $stable(rxcode_reg))
        else $error("Receive data taken during power-down");
    a_rx_mute: assert property ($rose(ctrl_reg[CTRL_RXSLP]) |=>
        analog_rx_out && !rx_conv_en_out)
        else $error("Analog output not grounded in power-down");
    a_sleep_split: assert property ($rose(ctrl_reg[CTRL_TXSLP])
        && !ctrl_reg[CTRL_RXSLP] |=> !tx_conv_en_out
        && rx_conv_en_out)
        else $error("Power-down halves not independent");
    a_tx_gain: assert property ($fell(ctrl_reg[CTRL_TXG]) |=>
        tx_gain_low_out ##1 tx_gain_low_out)
        else $error("Transmit gain not lowered");
    a_rx_gain: assert property ($rose(ctrl_reg[CTRL_RXG]) |=>
        rx_gain_boost_out)
        else $error("Receive gain not raised");
    a_law_pin: assert property ($fell(ctrl_reg[CTRL_LAW]) |=>
        law_alaw_out)
        else $error("A-law not selected");
    a_new_flag: assert property (s_rx_frame |=> rx_new_reg)
        else $error("New sample flag not set");
endmodule

`default_nettype wire

// [pcs_pkg.sv]
// Constants, register map and state codes for the PCM codec serial port.
// Assumes a 100 MHz system clock and an APB master on the register side.
`default_nettype none

package pcs_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned CTRL_W = 5;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TXCODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RXCODE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

    // Control fields
    localparam int unsigned CTRL_LAW = 0;
    localparam int unsigned CTRL_TXG = 1;
    localparam int unsigned CTRL_RXG = 2;
    localparam int unsigned CTRL_RXSLP = 3;
    localparam int unsigned CTRL_TXSLP = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

    // Status fields
    localparam int unsigned STAT_ACTIVE = 0;
    localparam int unsigned STAT_RXNEW = 1;

    // Line formatting masks and reset codes
    localparam logic [CODE_W-1:0] MU_MASK = 8'hff;
    localparam logic [CODE_W-1:0] A_MASK = 8'h55;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [CODE_W-1:0] LINE_IDLE = 8'hff;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // Bit counter of one code word
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_LAST = 3'h7;

    typedef enum logic [1:0] {
        PCS_IDLE = 2'b01,
        PCS_SHIFT = 2'b10
    } pcs_state_e;
endpackage

`default_nettype wire

// [pcs_link.sv]
// Bit clock domain of the PCM codec serial port: frame start, shifting.
// Assumes tx_word_in is held stable around frame starts by the caller.
`default_nettype none

module pcs_link (
    input wire logic bclk_in,                      // Bit clock
    input wire logic rst_n_in,                     // System reset, synced to bit clock here
    input wire logic frame_sync_in,                // Frame sync pin
    input wire logic chan_sel_n_in,                // Channel select, low
    input wire logic pcm_rx_in,                    // Serial receive data
    input wire logic tx_sleep_in,                  // Transmit power-down
    input wire logic [pcs_pkg::CODE_W-1:0] tx_word_in, // Line code to send
    output logic pcm_tx_out,                       // Serial transmit data
    output logic pcm_tx_oe_out,                    // Transmit drive enable
    output logic [pcs_pkg::CODE_W-1:0] rx_word_out, // Last received code
    output logic rx_tgl_out,                       // Toggles per frame
    output logic active_out                        // First frame seen
);
    import pcs_pkg::*;

    logic rst_s1_reg;
    logic link_rst_n_reg;
    logic slp_s1_reg;
    logic tx_sleep_s_reg;
    logic fs_prev_reg;
    logic oe_reg;
    logic active_reg;
    logic rx_tgl_reg;
    pcs_state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic [CODE_W-1:0] shift_reg;
    logic [CODE_W-1:0] rx_sh_reg;
    logic [CODE_W-1:0] rx_word_reg;
    logic start;

    always_ff @(posedge bclk_in)
    begin
        rst_s1_reg <= rst_n_in;
        link_rst_n_reg <= rst_s1_reg;
    end

    always_ff @(posedge bclk_in)
    begin
        if (!link_rst_n_reg)
        begin
            slp_s1_reg <= 1'b0;
            tx_sleep_s_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end
        else
        begin
            slp_s1_reg <= tx_sleep_in;
            tx_sleep_s_reg <= slp_s1_reg;
            fs_prev_reg <= frame_sync_in;
        end
    end

    // Sync edge counts only with the channel selected
    assign start = frame_sync_in & ~fs_prev_reg & ~chan_sel_n_in;

    always_ff @(posedge bclk_in)
    begin
        if (!link_rst_n_reg)
        begin
            state_reg <= PCS_IDLE;
            bit_cnt_reg <= CNT_ZERO;
            shift_reg <= LINE_IDLE;
            oe_reg <= 1'b0;
            active_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                PCS_IDLE:
                begin
                    oe_reg <= 1'b0;
                    if (start)
                    begin
                        active_reg <= 1'b1;
                        state_reg <= PCS_SHIFT;
                        bit_cnt_reg <= CNT_ZERO;
                        shift_reg <= tx_word_in;
                        oe_reg <= ~tx_sleep_s_reg;
                    end
                end
                PCS_SHIFT:
                begin
                    oe_reg <= oe_reg & ~tx_sleep_s_reg;
                    if (bit_cnt_reg == CNT_LAST)
                    begin
                        state_reg <= PCS_IDLE;
                        oe_reg <= 1'b0;
                    end
                    else
                    begin
                        // MSB first, one bit per rising edge
                        bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
                        shift_reg <= {shift_reg[CODE_W-2:0], 1'b0};
                    end
                end
                default:
                begin
                    state_reg <= PCS_IDLE;
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Receive bits are taken on the falling edge, mid bit
    always_ff @(negedge bclk_in)
    begin
        if (!link_rst_n_reg)
        begin
            rx_sh_reg <= CODE_ZERO;
            rx_word_reg <= CODE_ZERO;
            rx_tgl_reg <= 1'b0;
        end
        else if (state_reg == PCS_SHIFT)
        begin
            rx_sh_reg <= {rx_sh_reg[CODE_W-2:0], pcm_rx_in};
            if (bit_cnt_reg == CNT_LAST)
            begin
                rx_word_reg <= {rx_sh_reg[CODE_W-2:0], pcm_rx_in};
                rx_tgl_reg <= ~rx_tgl_reg;
            end
        end
    end

    assign pcm_tx_out = shift_reg[CODE_W-1];
    assign pcm_tx_oe_out = oe_reg;
    assign rx_word_out = rx_word_reg;
    assign rx_tgl_out = rx_tgl_reg;
    assign active_out = active_reg;

    sequence s_start;
        state_reg == PCS_IDLE && start && !tx_sleep_s_reg;
    endsequence

    a_frame_drive: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg) s_start |=> pcm_tx_oe_out
        && pcm_tx_out == $past(tx_word_in[CODE_W-1]))
        else $error("Frame start did not drive first bit");
    a_frame_length: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg) s_start |=>
        (pcm_tx_oe_out || tx_sleep_s_reg)[*8] ##1 !pcm_tx_oe_out)
        else $error("Output not released after eight bits");
    a_sleep_hiz: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg)
        tx_sleep_s_reg |=> !pcm_tx_oe_out)
        else $error("Output driven during transmit power-down");
    a_unselected_frame: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg) state_reg == PCS_IDLE
        && frame_sync_in && !fs_prev_reg && chan_sel_n_in
        |=> !pcm_tx_oe_out && state_reg == PCS_IDLE)
        else $error("Frame taken while channel not selected");
    a_inactive_hiz: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg)
        !active_reg |-> !pcm_tx_oe_out)
        else $error("Output driven before first frame");
    a_msb_order: assert property (@(posedge bclk_in)
        disable iff (!link_rst_n_reg)
        state_reg == PCS_SHIFT && bit_cnt_reg != CNT_LAST
        |=> pcm_tx_out == $past(shift_reg[CODE_W-2]))
        else $error("Transmit bit order broken");
endmodule

`default_nettype wire

// [pcs_bus_model.sv]
// Model of the TDM bus controller that faces the codec serial port.
// Assumes the codec shifts one byte per selected frame on its bit clock.
`default_nettype none

module pcs_bus_model (
    output var logic bclk_out,       // Bit clock, 64 ns period
    output var logic frame_sync_out, // Frame sync pulse
    output var logic chan_sel_n_out, // Channel select, low
    output var logic pcm_rx_out,     // Serial data to the codec
    input wire logic pcm_tx_in,      // Serial data from the codec
    input wire logic pcm_tx_oe_in    // Codec drives pcm_tx_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;

    // Master clock; each frame sync is launched after one of its edges
    initial
    begin
        mclk = 1'b0;
        forever #244.141 mclk = ~mclk;
    end

    // Free running bit clock, phase offset from the system clock
    initial
    begin
        bclk_out = 1'b0;
        frame_sync_out = 1'b0;
        chan_sel_n_out = 1'b1;
        pcm_rx_out = 1'b0;
        #7;
        forever #32 bclk_out = ~bclk_out;
    end

    // One frame; spacing is far shorter than 8 kHz to bound the run
    task automatic run_frame(input logic sel_n, input logic [7:0] rx,
                             output logic [7:0] tx, output int oe_cnt);
        tx = 8'h00;
        oe_cnt = 0;
        @(posedge mclk);
        repeat (6) @(posedge bclk_out);
        frame_sync_out <= 1'b1;
        chan_sel_n_out <= sel_n;
        for (int k = 0; k < 12; k++)
        begin
            @(posedge bclk_out);
            if (k == 1) frame_sync_out <= 1'b0;
            if (k == 2) chan_sel_n_out <= 1'b1;
            // Bits MSB first, then a toggling pattern once released
            pcm_rx_out <= (k < 8) ? rx[7 - k] : ~pcm_rx_out;
            @(negedge bclk_out);
            if (pcm_tx_oe_in === 1'b1)
            begin
                oe_cnt++;
                if (k < 8) tx[7 - k] = pcm_tx_in;
            end
        end
    endtask
endmodule

`default_nettype wire

// [pcs_codec_port_tb.sv]
// Self-checking bench of the codec serial port: APB side and PCM frames.
// Assumes pcs_bus_model supplies bit clock, sync, select and rx data.
`default_nettype none

module pcs_codec_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;

    typedef struct packed {logic [4:0] ctrl; logic [5:0] pins;} pcs_row_s;
    // Pins: analog ground, tx -3 dB, rx +3 dB, A-law, tx on, rx on
    pcs_row_s rows [4] = '{'{5'h03, 6'h03}, '{5'h00, 6'h17},
                           '{5'h1c, 6'h3c}, '{5'h07, 6'h0b}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, bclk, fsync, sel_n, rx, tx, tx_oe;
    wire [5:0] pins;
    int errors = 0;
    int num_checks = 0;

    pcs_codec_port u_pcs_codec_port (
        .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .bclk_in(bclk), .frame_sync_in(fsync),
        .chan_sel_n_in(sel_n), .pcm_rx_in(rx), .pcm_tx_out(tx),
        .pcm_tx_oe_out(tx_oe), .analog_rx_out(pins[5]),
        .tx_gain_low_out(pins[4]), .rx_gain_boost_out(pins[3]),
        .law_alaw_out(pins[2]), .tx_conv_en_out(pins[1]),
        .rx_conv_en_out(pins[0])
    );

    pcs_bus_model u_pcs_bus_model (
        .bclk_out(bclk), .frame_sync_out(fsync), .chan_sel_n_out(sel_n),
        .pcm_rx_out(rx), .pcm_tx_in(tx), .pcm_tx_oe_in(tx_oe)
    );

    always #5 clk = ~clk;

    task automatic finish_test();
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready at the access edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask

    // Frame through the model; results settle a few clocks after it
    task automatic do_frame(input logic s, input logic [7:0] rxb,
                            input logic [7:0] exp_tx, input int exp_oe);
        logic [7:0] t;
        int c;
        u_pcs_bus_model.run_frame(s, rxb, t, c);
        repeat (10) @(posedge clk);
        chk(32'(c), 32'(exp_oe));
        if (exp_oe == 8) chk({24'h0, t}, {24'h0, exp_tx});
    endtask

    initial
    begin
        // Reset spans at least three bit clock edges for the link side
        repeat (20) @(posedge clk);
        chk({26'h0, pins}, 32'h3);
        rst_n <= 1'b1;
        rd_chk(OFF_CTRL, {27'h0, CTRL_RESET}, 1'b0);
        rd_chk(OFF_TXCODE, 32'h0, 1'b0);
        rd_chk(OFF_STATUS, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        foreach (rows[i])
        begin
            wr(OFF_CTRL, {27'h0, rows[i].ctrl});
            @(posedge clk);
            @(posedge clk);
            chk({26'h0, pins}, {26'h0, rows[i].pins});
            rd_chk(OFF_CTRL, {27'h0, rows[i].ctrl}, 1'b0);
        end
        wr(OFF_CTRL, 32'h3);
        do_frame(1'b1, 8'h5a, 8'h00, 0);
        rd_chk(OFF_STATUS, 32'h0, 1'b0);
        wr(OFF_TXCODE, 32'h3c);
        do_frame(1'b0, 8'h5a, LINE_IDLE, 8);
        rd_chk(OFF_RXCODE, {24'h0, 8'h5a ^ MU_MASK}, 1'b0);
        rd_chk(OFF_STATUS, 32'h3, 1'b0);
        wr(OFF_STATUS, 32'h2);
        rd_chk(OFF_STATUS, 32'h1, 1'b0);
        do_frame(1'b0, 8'h96, 8'h3c ^ MU_MASK, 8);
        wr(OFF_CTRL, 32'h2);
        wr(OFF_TXCODE, 32'h81);
        do_frame(1'b0, 8'h96, 8'h3c ^ MU_MASK, 8);
        rd_chk(OFF_RXCODE, {24'h0, 8'h96 ^ A_MASK}, 1'b0);
        wr(OFF_CTRL, 32'ha);
        wr(OFF_STATUS, 32'h2);
        do_frame(1'b0, 8'h33, 8'h81 ^ A_MASK, 8);
        rd_chk(OFF_RXCODE, {24'h0, 8'h96 ^ A_MASK}, 1'b0);
        rd_chk(OFF_STATUS, 32'h1, 1'b0);
        wr(OFF_CTRL, 32'h12);
        do_frame(1'b0, 8'h33, 8'h00, 0);
        rd_chk(OFF_RXCODE, {24'h0, 8'h33 ^ A_MASK}, 1'b0);
        rd_chk(OFF_STATUS, 32'h3, 1'b0);
        // Mid-run reset: pins, registers and the link start over
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        chk({26'h0, pins}, 32'h3);
        rst_n <= 1'b1;
        rd_chk(OFF_CTRL, {27'h0, CTRL_RESET}, 1'b0);
        rd_chk(OFF_STATUS, 32'h0, 1'b0);
        do_frame(1'b0, 8'h69, LINE_IDLE, 8);
        rd_chk(OFF_RXCODE, {24'h0, 8'h69 ^ MU_MASK}, 1'b0);
        finish_test();
    end

    initial
    begin
        #100_000;
        errors++;
        finish_test();
    end
endmodule

`default_nettype wire
